// *** logic/audio_serial_tx.sv ***
// transmit side of the multichannel audio serial port, slave timing
// assumes bit clock and frame sync come from an outside master
//
// Implementation choices: the register addresses and the plain strobed port.
module audio_serial_tx #(
   parameter int NUM_CH = audio_tx_pkg::NUM_CH
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic bit_clock,
   input wire logic frame_sync,
   input wire logic general_purpose_input,
   input audio_tx_pkg::bus_req_type bus_req,
   output logic [audio_tx_pkg::DATA_W-1:0] rdata,
   output audio_tx_pkg::lane_type serial_data,
   output audio_tx_pkg::lane_type general_purpose_output,
   output logic bus_hold_en,
   output logic bus_hold_value
);
   localparam int DW = audio_tx_pkg::DATA_W;

   typedef struct packed {
      audio_tx_pkg::ctrl_type ctrl;
      logic [audio_tx_pkg::DELAY_W-1:0] delay;
      audio_tx_pkg::ch_cfg_type [NUM_CH-1:0] chan;
      logic [NUM_CH-1:0][DW-1:0] sample;
      logic [NUM_CH-1:0][DW-1:0] shadow;
      logic [DW-1:0] rdata;
      logic fs_cap;
      logic active;
      logic [5:0] wait_cnt;
      logic [4:0] bit_idx;
      logic [5:0] slot;
      logic daisy_bit;
      audio_tx_pkg::lane_type lane0;
      audio_tx_pkg::lane_type lane1;
      logic hold_en;
      logic hold_val;
      logic [15:0] frame_cnt;
   } state_type;

   state_type st_q;
   state_type st_d;

   logic bclk_rise;
   logic bclk_fall;
   logic fs_level;
   logic daisy_level;
   logic eff_rise;
   logic eff_fall;
   logic launch;
   logic capture;
   logic fs_eff;
   logic start_ev;
   logic right_half;
   logic go;
   logic own0;
   logic [5:0] wait_v;
   logic [4:0] last_bit;

   // bit clock needs edges, the others only settled levels
   pin_sync bclk_sync (
      .clk(clk),
      .reset(reset),
      .pin(bit_clock),
      .level(),
      .rise(bclk_rise),
      .fall(bclk_fall)
   );

   pin_sync fs_sync (
      .clk(clk),
      .reset(reset),
      .pin(frame_sync),
      .level(fs_level),
      .rise(),
      .fall()
   );

   pin_sync daisy_sync (
      .clk(clk),
      .reset(reset),
      .pin(general_purpose_input),
      .level(daisy_level),
      .rise(),
      .fall()
   );

   always_comb
   begin
      logic own1;
      logic b0;
      logic b1;
      logic [4:0] idx;
      logic slot_end;
      logic fmt_live;
      st_d = st_q;
      own0 = 1'b0;
      own1 = 1'b0;
      b0 = 1'b0;
      b1 = 1'b0;
      idx = '0;
      slot_end = 1'b0;
      go = 1'b0;
      // reserved code idles the lanes instead of finishing an old frame
      fmt_live = !(&st_q.ctrl.serial_format_select);

      // register writes; read data stand one cycle only
      st_d.rdata = '0;
      if (bus_req.wr)
      begin
         if (bus_req.addr == audio_tx_pkg::REG_CTRL)
            st_d.ctrl = audio_tx_pkg::ctrl_type'(
               bus_req.wdata[audio_tx_pkg::CTRL_W-1:0]);
         if (bus_req.addr == audio_tx_pkg::REG_DELAY)
            st_d.delay = bus_req.wdata[audio_tx_pkg::DELAY_W-1:0];
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (bus_req.addr == audio_tx_pkg::REG_SLOT_BASE
                  + 8'(c) * audio_tx_pkg::REG_STRIDE)
               st_d.chan[c] = audio_tx_pkg::ch_cfg_type'(
                  bus_req.wdata[audio_tx_pkg::CH_CFG_W-1:0]);
            if (bus_req.addr == audio_tx_pkg::REG_DATA_BASE
                  + 8'(c) * audio_tx_pkg::REG_STRIDE)
               st_d.sample[c] = bus_req.wdata;
         end
      end
      if (bus_req.rd)
      begin
         if (bus_req.addr == audio_tx_pkg::REG_CTRL)
            st_d.rdata = DW'(st_q.ctrl);
         if (bus_req.addr == audio_tx_pkg::REG_DELAY)
            st_d.rdata = DW'(st_q.delay);
         if (bus_req.addr == audio_tx_pkg::REG_STATUS)
            st_d.rdata = {9'h000, st_q.active, st_q.slot, st_q.frame_cnt};
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (bus_req.addr == audio_tx_pkg::REG_SLOT_BASE
                  + 8'(c) * audio_tx_pkg::REG_STRIDE)
               st_d.rdata = DW'(st_q.chan[c]);
            if (bus_req.addr == audio_tx_pkg::REG_DATA_BASE
                  + 8'(c) * audio_tx_pkg::REG_STRIDE)
               st_d.rdata = st_q.sample[c];
         end
      end

      // inversion swaps the edges seen by all formats
      eff_rise = st_q.ctrl.bit_clock_invert ? bclk_fall : bclk_rise;
      eff_fall = st_q.ctrl.bit_clock_invert ? bclk_rise : bclk_fall;
      fs_eff = fs_level ^ st_q.ctrl.frame_sync_invert;
      // tdm launches on rising, samples sync on falling
      // i2s and lj launch on falling, sample on rising
      if (st_q.ctrl.serial_format_select == audio_tx_pkg::FMT_TDM)
      begin
         launch = eff_rise;
         capture = eff_fall;
      end
      else
      begin
         launch = eff_fall;
         capture = eff_rise;
      end

      // only the sync edge matters, so any pulse width works
      if (capture)
         st_d.fs_cap = fs_eff;
      if (capture && st_q.ctrl.daisy_en)
         st_d.daisy_bit = daisy_level;

      // frame events per format, reserved code stays idle
      start_ev = 1'b0;
      right_half = 1'b0;
      if (capture && fs_eff != st_q.fs_cap)
      begin
         case (st_q.ctrl.serial_format_select)
            audio_tx_pkg::FMT_TDM: start_ev = fs_eff;
            audio_tx_pkg::FMT_I2S:
            begin
               start_ev = 1'b1;
               right_half = fs_eff;
            end
            audio_tx_pkg::FMT_LJ:
            begin
               start_ev = 1'b1;
               right_half = ~fs_eff;
            end
            default: start_ev = 1'b0;
         endcase
      end

      // delay adds offset and late latch; i2s waits a cycle
      wait_v = {1'b0, st_q.delay} + 6'(st_q.ctrl.late_latch)
         + 6'(st_q.ctrl.serial_format_select == audio_tx_pkg::FMT_I2S);
      last_bit = 5'(audio_tx_pkg::word_bits(st_q.ctrl.sample_word_length)
         - 6'h01);

      if (start_ev)
      begin
         // frame or left half starts at slot 0, right half at slot 32
         st_d.slot = right_half ? audio_tx_pkg::RIGHT_BASE : '0;
         st_d.bit_idx = '0;
         st_d.wait_cnt = wait_v;
         // zero wait sends the msb at once, ahead of a launch edge
         go = (wait_v == '0);
         st_d.active = go;
         if (!right_half)
         begin
            st_d.shadow = st_q.sample;
            st_d.frame_cnt = st_q.frame_cnt + 16'h0001;
         end
      end
      else if (launch && fmt_live && st_q.wait_cnt != '0)
      begin
         // msb goes out when the wait runs down
         st_d.wait_cnt = st_q.wait_cnt - 6'h01;
         go = (st_q.wait_cnt == audio_tx_pkg::WAIT_ONE);
         st_d.active = go;
      end
      else if (launch && fmt_live && st_q.active)
         go = 1'b1;
      else if (launch)
      begin
         // idle line released or held low after the frame
         st_d.lane0.oe = ~st_q.ctrl.release_en;
         st_d.lane1.oe = ~st_q.ctrl.release_en;
         st_d.lane0.d = 1'b0;
         st_d.lane1.d = 1'b0;
      end

      if (go)
      begin
         // msb first over the programmed word length
         idx = last_bit - st_d.bit_idx;
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (st_q.chan[c].enable && st_q.chan[c].slot == st_d.slot)
            begin
               if (st_q.chan[c].lane && st_q.ctrl.lane2_en)
               begin
                  own1 = 1'b1;
                  b1 = st_d.shadow[c][idx];
               end
               else
               begin
                  own0 = 1'b1;
                  b0 = st_d.shadow[c][idx];
               end
            end
         end
         if (own0)
            st_d.lane0 = '{d: b0, oe: 1'b1};
         // foreign slots repeat the upstream device
         else if (st_q.ctrl.daisy_en)
            st_d.lane0 = '{d: st_q.daisy_bit, oe: 1'b1};
         // release in slots this device does not use
         else if (st_q.ctrl.release_en)
            st_d.lane0.oe = 1'b0;
         else
            st_d.lane0 = '{d: 1'b0, oe: 1'b1};
         // second lane follows the same slot timing
         if (own1)
            st_d.lane1 = '{d: b1, oe: 1'b1};
         else
            st_d.lane1 = '{d: 1'b0, oe: ~st_q.ctrl.release_en};

         // step through slots with no idle bits
         if (st_q.ctrl.serial_format_select == audio_tx_pkg::FMT_TDM)
            slot_end = (st_d.slot == audio_tx_pkg::LAST_SLOT);
         else
            slot_end = (st_d.slot[4:0] == audio_tx_pkg::HALF_LAST);
         if (st_d.bit_idx == last_bit)
         begin
            st_d.bit_idx = '0;
            if (slot_end)
               st_d.active = 1'b0;
            else
               st_d.slot = st_d.slot + 6'h01;
         end
         else
            st_d.bit_idx = st_d.bit_idx + 5'h01;
      end

      if (!st_q.ctrl.lane2_en)
         st_d.lane1 = '0;
      // keeper holds the last value the device drove
      if (st_d.lane0.oe)
         st_d.hold_val = st_d.lane0.d;
      st_d.hold_en = st_q.ctrl.hold_en & ~st_d.lane0.oe;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_q <= '0;
         st_q.ctrl <= audio_tx_pkg::CTRL_RESET;
      end
      else
         st_q <= st_d;
   end

   // every output straight from the state register
   assign rdata = st_q.rdata;
   assign serial_data = st_q.lane0;
   assign general_purpose_output = st_q.lane1;
   assign bus_hold_en = st_q.hold_en;
   assign bus_hold_value = st_q.hold_val;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence tdm_start_s;
      start_ev && wait_v == '0
         && st_q.ctrl.serial_format_select == audio_tx_pkg::FMT_TDM;
   endsequence
   sequence i2s_left_s;
      start_ev && !right_half && wait_v == audio_tx_pkg::WAIT_ONE
         && st_q.ctrl.serial_format_select == audio_tx_pkg::FMT_I2S;
   endsequence

   tdm_frame_start_a: assert property (
      tdm_start_s |=> st_q.active && st_q.slot == '0
         && st_q.bit_idx == 5'h01)
      else $error("tdm frame did not start at slot 0");
   slot_order_a: assert property (
      go && !start_ev && st_q.active && st_q.bit_idx == last_bit
         && st_q.slot != audio_tx_pkg::LAST_SLOT
         && st_q.slot[4:0] != audio_tx_pkg::HALF_LAST
      |=> st_q.slot == $past(st_q.slot) + 6'h01)
      else $error("slot did not advance by one");
   tdm_launch_edge_a: assert property (
      $changed(st_q.lane0) && !$past(start_ev)
         && $past(st_q.ctrl.serial_format_select) == audio_tx_pkg::FMT_TDM
      |-> $past(eff_rise))
      else $error("tdm bit launched off the rising edge");
   i2s_left_msb_a: assert property (
      i2s_left_s |=> st_q.wait_cnt == audio_tx_pkg::WAIT_ONE && !st_q.active
         ##[1:16] (go && st_q.slot == '0 && st_q.bit_idx == '0))
      else $error("i2s left msb not on the next falling edge");
   i2s_launch_edge_a: assert property (
      $changed(st_q.lane0)
         && $past(st_q.ctrl.serial_format_select) == audio_tx_pkg::FMT_I2S
      |-> $past(eff_fall))
      else $error("i2s bit launched off the falling edge");
   lj_right_start_a: assert property (
      start_ev && right_half && wait_v == '0
         && st_q.ctrl.serial_format_select == audio_tx_pkg::FMT_LJ
      |=> st_q.slot == audio_tx_pkg::RIGHT_BASE && st_q.lane0.oe == 1'b1
         || !$past(own0))
      else $error("lj right half did not start at once");
   unused_release_a: assert property (
      go && !own0 && st_q.ctrl.release_en && !st_q.ctrl.daisy_en
      |=> !st_q.lane0.oe)
      else $error("line driven in an unused slot");
   bus_keeper_a: assert property (
      st_q.hold_en && $past(st_q.lane0.oe)
      |-> !st_q.lane0.oe && st_q.hold_val == $past(st_q.lane0.d))
      else $error("keeper lost the last driven value");
   second_lane_off_a: assert property (
      !$past(st_q.ctrl.lane2_en) |-> st_q.lane1 == '0)
      else $error("second lane active while disabled");
endmodule : audio_serial_tx

// *** logic/audio_tx_pkg.sv ***
// constants, field layouts and carrier types of the audio serial transmitter
// assumes a 40 MHz system clock and a bit clock far slower than it
package audio_tx_pkg;
   localparam int NUM_CH = 4;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // format codes
   localparam logic [1:0] FMT_TDM = 2'h0;
   localparam logic [1:0] FMT_I2S = 2'h1;
   localparam logic [1:0] FMT_LJ = 2'h2;

   // word length codes and their bit counts
   localparam logic [1:0] WLEN_16 = 2'h0;
   localparam logic [1:0] WLEN_20 = 2'h1;
   localparam logic [1:0] WLEN_24 = 2'h2;
   localparam logic [5:0] BITS_16 = 6'h10;
   localparam logic [5:0] BITS_20 = 6'h14;
   localparam logic [5:0] BITS_24 = 6'h18;
   localparam logic [5:0] BITS_32 = 6'h20;

   // slot numbering: right half of i2s and lj starts at slot 32
   localparam logic [5:0] RIGHT_BASE = 6'h20;
   localparam logic [5:0] LAST_SLOT = 6'h3F;
   localparam logic [4:0] HALF_LAST = 5'h1F;
   localparam logic [5:0] WAIT_ONE = 6'h01;

   // register offsets
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_DELAY = 8'h04;
   localparam logic [ADDR_W-1:0] REG_SLOT_BASE = 8'h08;
   localparam logic [ADDR_W-1:0] REG_DATA_BASE = 8'h18;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h28;
   localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04;

   // control register, bit 12 down to bit 0
   typedef struct packed {
      logic late_latch;
      logic daisy_en;
      logic lane2_en;
      logic hold_en;
      logic release_en;
      logic [1:0] serial_format_select;
      logic [1:0] sample_word_length;
      logic frame_sync_invert;
      logic bit_clock_invert;
      logic [1:0] unused;
   } ctrl_type;
   localparam int CTRL_W = $bits(ctrl_type);
   localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0030;
   localparam int DELAY_W = 5;

   // per channel slot register, bit 7 down to bit 0
   typedef struct packed {
      logic enable;
      logic lane;
      logic [5:0] slot;
   } ch_cfg_type;
   localparam int CH_CFG_W = $bits(ch_cfg_type);

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;

   typedef struct packed {
      logic d;
      logic oe;
   } lane_type;

   function automatic logic [5:0] word_bits(input logic [1:0] code);
      case (code)
         WLEN_16: word_bits = BITS_16;
         WLEN_20: word_bits = BITS_20;
         WLEN_24: word_bits = BITS_24;
         default: word_bits = BITS_32;
      endcase
   endfunction : word_bits
endpackage : audio_tx_pkg

// *** logic/pin_sync.sv ***
// two-flop synchroniser with edge detection for one slow pin
// assumes the pin changes no faster than a few system clocks
module pin_sync (
   input wire logic clk,
   input wire logic reset,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } sync_state_type;

   sync_state_type st_q;
   sync_state_type st_d;

   // first flop only feeds the second
   always_comb
   begin
      st_d = st_q;
      st_d.meta = pin;
      st_d.sync = st_q.meta;
      st_d.prev = st_q.sync;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   // edges use only the settled copies
   assign level = st_q.sync;
   assign rise = st_q.sync & ~st_q.prev;
   assign fall = ~st_q.sync & st_q.prev;
endmodule : pin_sync

// *** sim/audio_host_model.sv ***
// host side of the audio bus: makes bit clock and frame sync, samples lanes
// assumes the bench calls frame() and reads the capture arrays afterwards
module audio_host_model (
   output logic bit_clock,
   output logic frame_sync,
   input audio_tx_pkg::lane_type serial_data,
   input audio_tx_pkg::lane_type general_purpose_output
);
   timeunit 1ns;
   timeprecision 100ps;

   logic cap_d0 [0:255];
   logic cap_oe0 [0:255];
   logic cap_d1 [0:255];
   logic cap_oe1 [0:255];

   // clock stands still between frames
   initial
   begin
      bit_clock = 1'b0;
      frame_sync = 1'b0;
   end

   // two preamble cycles hold sync at the far level so the frame start is
   // always seen as a change; sampling 50 ns after a launch edge keeps clear
   // of the synchroniser delay on both sides of each bit
   // enough clocks per frame
   task automatic frame(input int n_bits, input int sync_w,
      input logic rise, input logic first, input logic second);
      int i;
      bit_clock = ~rise;
      #400;
      for (i = -2; i <= n_bits; i++)
      begin
         bit_clock = rise;
         frame_sync = (i < 0) ? ~first : ((i < sync_w) ? first : second);
         #50;
         if (i >= 1)
         begin
            // a released line reads back inverted, so a lost drive shows
            cap_d0[i - 1] = serial_data.oe ? serial_data.d : ~serial_data.d;
            cap_oe0[i - 1] = serial_data.oe;
            cap_d1[i - 1] = general_purpose_output.d;
            cap_oe1[i - 1] = general_purpose_output.oe;
         end
         #50;
         bit_clock = ~rise;
         #100;
      end
   endtask : frame
endmodule : audio_host_model

// *** sim/audio_serial_tx_bench.sv ***
// self-checking bench for the audio serial transmitter
// assumes the host model makes the link clock and captures both lanes
module audio_serial_tx_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk;
   logic reset;
   logic bit_clock;
   logic frame_sync;
   logic general_purpose_input;
   audio_tx_pkg::bus_req_type bus_req;
   logic [31:0] rdata;
   audio_tx_pkg::lane_type serial_data;
   audio_tx_pkg::lane_type general_purpose_output;
   logic bus_hold_en;
   logic bus_hold_value;
   int fails;
   int n_compared;

   audio_serial_tx dut (
      .clk(clk),
      .reset(reset),
      .bit_clock(bit_clock),
      .frame_sync(frame_sync),
      .general_purpose_input(general_purpose_input),
      .bus_req(bus_req),
      .rdata(rdata),
      .serial_data(serial_data),
      .general_purpose_output(general_purpose_output),
      .bus_hold_en(bus_hold_en),
      .bus_hold_value(bus_hold_value)
   );

   audio_host_model host (
      .bit_clock(bit_clock),
      .frame_sync(frame_sync),
      .serial_data(serial_data),
      .general_purpose_output(general_purpose_output)
   );

   // 40 MHz system clock
   always #12.5 clk = ~clk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // one write cycle, then an idle cycle so no strobe is set twice at once
   task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
      bus_req.addr <= addr;
      bus_req.wdata <= data;
      bus_req.wr <= 1'b1;
      @(posedge clk);
      bus_req.wr <= 1'b0;
      @(posedge clk);
   endtask : reg_write

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] addr, input logic [31:0] exp);
      bus_req.addr <= addr;
      bus_req.rd <= 1'b1;
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1;
      check(rdata, exp);
      @(posedge clk);
   endtask : reg_read

   task automatic set_ch(input int c, input logic [31:0] cfg,
      input logic [31:0] data);
      reg_write(audio_tx_pkg::REG_SLOT_BASE + 8'(c * 4), cfg);
      reg_write(audio_tx_pkg::REG_DATA_BASE + 8'(c * 4), data);
   endtask : set_ch

   // offset keeps link edges away from system clock edges
   task automatic play(input int n_bits, input int sync_w,
      input logic rise, input logic first, input logic second);
      @(posedge clk);
      #5;
      host.frame(n_bits, sync_w, rise, first, second);
      repeat (8) @(posedge clk);
   endtask : play

   // every bit of a slot must be driven, msb first
   task automatic check_slot(input int lane, input int at,
      input logic [31:0] data, input int wl);
      int k;
      logic [1:0] got;
      for (k = 0; k < wl; k++)
      begin
         got = {host.cap_oe0[at + k], host.cap_d0[at + k]};
         if (lane == 1)
            got = {host.cap_oe1[at + k], host.cap_d1[at + k]};
         check({30'h0, got}, {30'h0, 1'b1, data[wl - 1 - k]});
      end
   endtask : check_slot

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done

   // a hang anywhere ends the run through the same closing task
   initial
   begin
      #500000;
      fails++;
      test_done();
   end

   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      bus_req = '0;
      general_purpose_input = 1'b0;
      fails = 0;
      n_compared = 0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      // reset values, narrow fields and an unmapped place
      reg_read(audio_tx_pkg::REG_CTRL, 32'h00000030);
      reg_read(audio_tx_pkg::REG_DELAY, 32'h00000000);
      reg_write(audio_tx_pkg::REG_DELAY, 32'hFFFFFFFF);
      reg_read(audio_tx_pkg::REG_DELAY, 32'h0000001F);
      reg_write(8'h0C, 32'hFFFFFFFF);
      reg_read(8'h0C, 32'h000000FF);
      reg_write(8'hFC, 32'hFFFFFFFF);
      reg_read(8'hFC, 32'h00000000);
      reg_write(audio_tx_pkg::REG_DELAY, 32'h0);
      $display("register test done");
      // tdm, 16 bits, one-cycle sync, released gaps, keeper, second lane
      set_ch(0, 32'h80, 32'h0000B38F);
      set_ch(1, 32'h81, 32'h00005A1D);
      set_ch(2, 32'hC3, 32'h0000C6E9);
      reg_write(audio_tx_pkg::REG_CTRL, 32'h00000700);
      play(80, 1, 1'b1, 1'b1, 1'b0);
      check_slot(0, 0, 32'h0000B38F, 16);
      check_slot(0, 16, 32'h00005A1D, 16);
      check({31'h0, host.cap_oe0[40]}, 32'h0);
      check_slot(1, 48, 32'h0000C6E9, 16);
      #1;
      check({30'h0, bus_hold_en, bus_hold_value}, 32'h3);
      reg_read(audio_tx_pkg::REG_STATUS, 32'h00450001);
      $display("tdm slot test done");
      // tdm, 24 bits, wide sync, start delay plus late latching
      set_ch(0, 32'h0, 32'h0);
      set_ch(1, 32'h0, 32'h0);
      set_ch(2, 32'h82, 32'h00D35A71);
      reg_write(audio_tx_pkg::REG_DELAY, 32'h2);
      reg_write(audio_tx_pkg::REG_CTRL, 32'h00001120);
      play(77, 3, 1'b1, 1'b1, 1'b0);
      check_slot(0, 51, 32'h00D35A71, 24);
      $display("tdm delay test done");
      // i2s, 20 bits, left and right halves of 22 clocks
      reg_write(audio_tx_pkg::REG_DELAY, 32'h0);
      set_ch(0, 32'h80, 32'h0009C3A5);
      set_ch(1, 32'hA0, 32'h0006B2D4);
      set_ch(2, 32'h0, 32'h0);
      reg_write(audio_tx_pkg::REG_CTRL, 32'h00000150);
      play(44, 22, 1'b0, 1'b0, 1'b1);
      check_slot(0, 1, 32'h0009C3A5, 20);
      check_slot(0, 23, 32'h0006B2D4, 20);
      $display("i2s test done");
      // left-justified, 32 bits, both pins inverted, daisy fills slot 1
      general_purpose_input <= 1'b1;
      set_ch(0, 32'h80, 32'hC3A55A3C);
      set_ch(1, 32'hA0, 32'h96E10F87);
      reg_write(audio_tx_pkg::REG_CTRL, 32'h000009BC);
      play(68, 34, 1'b1, 1'b0, 1'b1);
      check_slot(0, 0, 32'hC3A55A3C, 32);
      check_slot(0, 34, 32'h96E10F87, 32);
      check({30'h0, host.cap_oe0[32], host.cap_d0[32]}, 32'h3);
      $display("lj test done");
      // reserved format code sends nothing
      general_purpose_input <= 1'b0;
      reg_write(audio_tx_pkg::REG_CTRL, 32'h000001F0);
      play(20, 1, 1'b1, 1'b1, 1'b0);
      for (int k = 0; k < 20; k++)
         check({31'h0, host.cap_oe0[k]}, 32'h0);
      $display("reserved format test done");
      test_done();
   end
endmodule : audio_serial_tx_bench
